// >>> rtl/pirq_pkg.sv
package pirq_pkg;
  localparam int PIRQ_PINS_SMALL = 8;
  localparam int PIRQ_PINS_LARGE = 16;
  localparam int PIRQ_EDGE_GROUPS = 7;
  localparam int PIRQ_LEVEL_GROUP_NUM = 12;
  localparam int PIRQ_GROUP_WIDTH = 32;
  localparam int PIRQ_UNITS = 6;
  localparam int PIRQ_EVENT_LINKS = 2;
  localparam int PIRQ_FILT_SAMPLES = 3;
  localparam int PIRQ_FILT_DIV_W = 8;
  localparam int PIRQ_FILT_DIV1_W = 3;
  localparam int PIRQ_FILT_DIV2_W = 5;
  localparam int PIRQ_FILT_DIV3_W = 6;
  localparam logic [1:0] PIRQ_DET_LOW = 2'h0;
  localparam logic [1:0] PIRQ_DET_FALL = 2'h1;
  localparam logic [1:0] PIRQ_DET_RISE = 2'h2;
  localparam logic [1:0] PIRQ_DET_BOTH = 2'h3;
  typedef enum logic [1:0] {
    PIRQ_RUN = 2'b00,
    PIRQ_SLEEP = 2'b01,
    PIRQ_CLKSTOP = 2'b10,
    PIRQ_STANDBY = 2'b11
  } pirq_mode_t;
endpackage

// >>> rtl/pirq_pin_filter.sv
`timescale 1ns/1ps
`default_nettype none
module pirq_pin_filter
  import pirq_pkg::*;
#(
  parameter int SAMPLES = PIRQ_FILT_SAMPLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic pin_sync,
  input wire logic filt_en,
  input wire logic sample_en,
  output logic pin_clean
);
  // Counter is four bits wide, so the run length is capped
  if (SAMPLES < 2 || SAMPLES > 15)
  begin : g_bad_samples
    $error("pirq_pin_filter: SAMPLES out of range");
  end
  logic [3:0] cnt_r, cnt_nxt;
  logic out_r, out_nxt;
  logic last_r, last_nxt;
  always_comb
  begin
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    last_nxt = last_r;
    if (!filt_en)
    begin
      out_nxt = pin_sync;
      last_nxt = pin_sync;
      cnt_nxt = 4'h0;
    end
    else if (sample_en)
    begin
      last_nxt = pin_sync;
      // Level accepted only after SAMPLES equal filter-clock samples
      if (pin_sync != last_r)
        cnt_nxt = 4'h1;
      else if (cnt_r < 4'(SAMPLES))
        cnt_nxt = cnt_r + 4'h1;
      if (pin_sync == last_r && cnt_r + 4'h1 >= 4'(SAMPLES))
        out_nxt = pin_sync;
    end
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cnt_r <= 4'h0;
      out_r <= 1'b1;
      last_r <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
      last_r <= last_nxt;
    end
  end
  assign pin_clean = out_r;
endmodule
`default_nettype wire

// >>> rtl/pirq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module pirq_ctrl
  import pirq_pkg::*;
#(
  parameter bit LARGE = 1'b1,
  parameter int NPIN = LARGE ? PIRQ_PINS_LARGE : PIRQ_PINS_SMALL,
  parameter int NPER = 16,
  parameter logic [NPER-1:0] PER_IS_EDGE = '1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [NPIN-1:0] irq_pin,
  input wire logic [2*NPIN-1:0] pin_detect_sel,
  input wire logic [NPIN-1:0] pin_filter_enable_upper,
  input wire logic [2*NPIN-1:0] pin_filter_setting_upper,
  input wire logic [NPIN-1:0] pin_clear,
  input wire logic [NPER-1:0] per_req,
  input wire logic [NPER-1:0] per_enable,
  input wire logic [NPER-1:0] per_ack,
  input wire logic [PIRQ_EVENT_LINKS-1:0] event_link_controller_evt,
  input wire logic [PIRQ_EVENT_LINKS-1:0] event_link_ack,
  input wire logic [PIRQ_EDGE_GROUPS*PIRQ_GROUP_WIDTH-1:0] grp_edge_src,
  input wire logic [PIRQ_GROUP_WIDTH-1:0] grp_level_src,
  input wire logic [(PIRQ_EDGE_GROUPS+1)*PIRQ_GROUP_WIDTH-1:0] group_member_enables,
  input wire logic [PIRQ_EDGE_GROUPS*PIRQ_GROUP_WIDTH-1:0] group_member_clears,
  input wire logic [2*PIRQ_UNITS-1:0] unit_req,
  input wire logic [PIRQ_UNITS-1:0] unit_sel,
  input wire logic [1:0] power_mode,
  input wire logic nmi,
  input wire logic eight_bit_timer_irq,
  input wire logic clock_alarm_irq,
  output logic [NPIN-1:0] pin_pending,
  output logic [NPER-1:0] per_pending,
  output logic [PIRQ_EVENT_LINKS-1:0] event_link_pending,
  output logic [(PIRQ_EDGE_GROUPS+1)*PIRQ_GROUP_WIDTH-1:0] group_source_flags,
  output logic [PIRQ_EDGE_GROUPS:0] group_irq,
  output logic [PIRQ_UNITS-1:0] unit_irq,
  output logic wake
);
  localparam int GW = PIRQ_GROUP_WIDTH;
  localparam int GE = PIRQ_EDGE_GROUPS * GW;
  if (NPIN != (LARGE ? PIRQ_PINS_LARGE : PIRQ_PINS_SMALL))
  begin : g_bad_npin
    $error("pirq_ctrl: NPIN does not match variant");
  end
  if (NPER < 1)
  begin : g_bad_nper
    $error("pirq_ctrl: NPER must be at least one");
  end

  // Pins come from outside: two flops before any use
  logic [NPIN-1:0] s1_r, s2_r, clean, clean_d_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s1_r <= '1;
      s2_r <= '1;
    end
    else
    begin
      s1_r <= irq_pin;
      s2_r <= s1_r;
    end
  end

  // Shared filter-clock divider; setting picks 1, 8, 32 or 64 clocks
  logic [PIRQ_FILT_DIV_W-1:0] div_r, div_nxt;
  logic [NPIN-1:0] smp_en;
  always_comb
  begin
    div_nxt = div_r + PIRQ_FILT_DIV_W'(1);
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      div_r <= 8'h00;
    else
      div_r <= div_nxt;
  end

  genvar i;
  generate
    for (i = 0; i < NPIN; i++)
    begin : g_pin
      logic [1:0] fs;
      assign fs = pin_filter_setting_upper[2*i +: 2];
      // One shared divider keeps all pins on a common sample grid
      assign smp_en[i] = (fs == 2'h0) ? 1'b1 :
                         (fs == 2'h1) ? (div_r[PIRQ_FILT_DIV1_W-1:0] == '0) :
                         (fs == 2'h2) ? (div_r[PIRQ_FILT_DIV2_W-1:0] == '0) :
                         (div_r[PIRQ_FILT_DIV3_W-1:0] == '0);
      pirq_pin_filter #(.SAMPLES(PIRQ_FILT_SAMPLES)) u_filt
      (
        .clk(clk),
        .reset(reset),
        .pin_sync(s2_r[i]),
        .filt_en(pin_filter_enable_upper[i]),
        .sample_en(smp_en[i]),
        .pin_clean(clean[i])
      );
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (reset)
      clean_d_r <= '1;
    else
      clean_d_r <= clean;
  end

  // Pin detection: each pin an independent source
  logic [NPIN-1:0] pin_r, pin_nxt, rise, fall;
  always_comb
  begin
    pin_nxt = pin_r;
    rise = clean & ~clean_d_r;
    fall = ~clean & clean_d_r;
    for (int k = 0; k < NPIN; k++)
    begin
      unique case (pin_detect_sel[2*k +: 2])
        PIRQ_DET_LOW: pin_nxt[k] = ~clean[k];
        PIRQ_DET_FALL: pin_nxt[k] = fall[k] | (pin_r[k] & ~pin_clear[k]);
        PIRQ_DET_RISE: pin_nxt[k] = rise[k] | (pin_r[k] & ~pin_clear[k]);
        PIRQ_DET_BOTH: pin_nxt[k] = rise[k] | fall[k] | (pin_r[k] & ~pin_clear[k]);
      endcase
    end
  end

  // Peripheral detection type fixed at build time
  logic [NPER-1:0] per_d_r, per_r, per_nxt;
  always_comb
  begin
    for (int k = 0; k < NPER; k++)
      per_nxt[k] = PER_IS_EDGE[k] ? ((per_req[k] & ~per_d_r[k]) | (per_r[k] & ~per_ack[k]))
                                  : per_req[k];
  end

  // Event link requests latch until taken in the small variant; the large variant holds them at zero
  logic [PIRQ_EVENT_LINKS-1:0] ev_r, ev_nxt;
  always_comb
  begin
    ev_nxt = LARGE ? '0 : (event_link_controller_evt | (ev_r & ~event_link_ack));
  end

  // Groups (large variant only): edge groups latch with set over clear, level group follows sources
  logic [(PIRQ_EDGE_GROUPS+1)*GW-1:0] gf_r, gf_nxt;
  logic [PIRQ_EDGE_GROUPS:0] gi_nxt;
  always_comb
  begin
    gf_nxt = '0;
    gi_nxt = '0;
    if (LARGE)
    begin
      gf_nxt[GE-1:0] = grp_edge_src | (gf_r[GE-1:0] & ~group_member_clears);
      gf_nxt[GE +: GW] = grp_level_src;
      for (int g = 0; g <= PIRQ_EDGE_GROUPS; g++)
        gi_nxt[g] = |(gf_nxt[g*GW +: GW] & group_member_enables[g*GW +: GW]);
    end
  end

  // Unit selection of one of two requesters
  logic [PIRQ_UNITS-1:0] ui_nxt;
  always_comb
  begin
    for (int u = 0; u < PIRQ_UNITS; u++)
      ui_nxt[u] = LARGE & (unit_sel[u] ? unit_req[2*u+1] : unit_req[2*u]);
  end

  // Wake decision by power mode; the eight-bit timer cannot end standby, the clock alarm can
  logic wake_nxt, any_en;
  always_comb
  begin
    any_en = (|pin_r) | (|(per_r & per_enable)) | (|ev_r) | (|gi_nxt) | (|ui_nxt);
    unique case (pirq_mode_t'(power_mode))
      PIRQ_RUN: wake_nxt = 1'b0;
      // Sleep keeps every source live, timer and clock alarm included
      PIRQ_SLEEP: wake_nxt = nmi | any_en | eight_bit_timer_irq | clock_alarm_irq;
      PIRQ_CLKSTOP: wake_nxt = nmi | (|pin_r) | eight_bit_timer_irq | clock_alarm_irq;
      PIRQ_STANDBY: wake_nxt = nmi | (|pin_r) | clock_alarm_irq;
    endcase
  end

  logic [PIRQ_EDGE_GROUPS:0] gi_r;
  logic [PIRQ_UNITS-1:0] ui_r;
  logic wake_r;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pin_r <= '0;
      per_d_r <= '0;
      per_r <= '0;
      ev_r <= '0;
      gf_r <= '0;
      gi_r <= '0;
      ui_r <= '0;
      wake_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      per_d_r <= per_req;
      per_r <= per_nxt;
      ev_r <= ev_nxt;
      gf_r <= gf_nxt;
      gi_r <= gi_nxt;
      ui_r <= ui_nxt;
      wake_r <= wake_nxt;
    end
  end

  assign pin_pending = pin_r;
  assign per_pending = per_r;
  assign event_link_pending = ev_r;
  assign group_source_flags = gf_r;
  assign group_irq = gi_r;
  assign unit_irq = ui_r;
  assign wake = wake_r;
endmodule
`default_nettype wire

// >>> tb/pirq_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pirq_ctrl_assertions
  import pirq_pkg::*;
#(
  parameter int NPIN = 16,
  parameter int NPER = 16
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [NPER-1:0] per_req,
  input wire logic [NPER-1:0] per_ack,
  input wire logic [NPER-1:0] per_pending,
  input wire logic [2*PIRQ_UNITS-1:0] unit_req,
  input wire logic [PIRQ_UNITS-1:0] unit_sel,
  input wire logic [PIRQ_UNITS-1:0] unit_irq,
  input wire logic [1:0] power_mode,
  input wire logic nmi,
  input wire logic eight_bit_timer_irq,
  input wire logic clock_alarm_irq,
  input wire logic [NPIN-1:0] pin_pending,
  input wire logic wake
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);
  a_per_latch: assert property ($rose(per_req[0]) |=> per_pending[0]) else $error("edge lost");
  a_per_hold: assert property (per_pending[0] && !per_ack[0] |=> per_pending[0]) else $error("pend lost");
  a_per_ack: assert property (per_ack[0] && !per_req[0] |=> !per_pending[0]) else $error("ack lost");
  a_unit_odd: assert property (unit_sel[0] |=> unit_irq[0] == $past(unit_req[1])) else $error("unit odd");
  a_unit_even: assert property (!unit_sel[0] |=> unit_irq[0] == $past(unit_req[0])) else $error("unit even");
  a_nmi_wake: assert property (nmi && power_mode != 2'h0 |-> ##[1:2] wake) else $error("nmi wake");
  a_stop_timer: assert property (power_mode == 2'h2 && eight_bit_timer_irq |-> ##[1:2] wake) else $error("stop");
  a_sleep_timer: assert property (power_mode == 2'h1 && eight_bit_timer_irq |-> ##[1:2] wake) else $error("sleep");
  // Three quiet cycles let a cause from the previous mode drain out first
  a_sby_timer: assert property (
    (power_mode == 2'h3 && !nmi && !clock_alarm_irq && pin_pending == '0) [*3] |-> !wake) else $error("standby");
endmodule
bind pirq_ctrl pirq_ctrl_assertions #(.NPIN(NPIN), .NPER(NPER)) i_chk (.*);
`default_nettype wire

// >>> tb/pirq_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module pirq_core_model
(
  input wire logic reset,
  input wire logic [15:0] per_pending,
  input wire logic [15:0] stall,
  output logic [15:0] per_ack
);
  // Core accepts a pending request unless stalled; a stall keeps an edge-detected request pending
  // Combinational, so a stall changed at the falling edge cannot race the model
  assign per_ack = reset ? 16'h0000 : per_pending & ~stall;
endmodule
`default_nettype wire

// >>> tb/pin_and_peripheral_irq_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pin_and_peripheral_irq_ctrl_tb_top
  import pirq_pkg::*;
;
  logic clk = 0, reset = 1, nmi = 0, eight_bit_timer_irq = 0, clock_alarm_irq = 0, wake;
  logic [15:0] irq_pin = '1, pin_filter_enable_upper = '0, pin_clear = '0, per_req = '0, per_enable = '1;
  logic [15:0] per_ack, pin_pending, per_pending, stall = '0, e;
  logic [31:0] pin_detect_sel = '0, pin_filter_setting_upper = '0, grp_level_src = '0, r, seed = 32'hbfe2_0a71;
  logic [1:0] event_link_controller_evt = '0, event_link_ack = '0, power_mode = '0, event_link_pending;
  logic [223:0] grp_edge_src = '0, group_member_clears = '0;
  logic [255:0] group_member_enables = '1, group_source_flags;
  logic [11:0] unit_req = '0;
  logic [5:0] unit_sel = '0, unit_irq;
  logic [7:0] group_irq;
  int failures = 0, n_checks = 0, cycles = 0, k;
  logic [15:0] pr_req = '0, pr_pend = '0;
  // Top peripheral line is level-detected so both build-time types are exercised
  localparam logic [15:0] PER_EDGE = 16'h7fff;
  always #5 clk = ~clk;
  pirq_ctrl #(.PER_IS_EDGE(PER_EDGE)) i_dut (.*);
  pirq_core_model i_core (.*);
  function automatic logic pend(input logic [1:0] m, input logic lv, input logic f, input logic rs);
    return m == PIRQ_DET_LOW ? !lv : (m == PIRQ_DET_FALL && f) || (m == PIRQ_DET_RISE && rs) || (m == PIRQ_DET_BOTH);
  endfunction
  task automatic chk(input string what, input logic [255:0] exp, input logic [255:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("FAIL %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      print_verdict;
    end
  end
  initial
  begin
    cyc(2);
    reset = 0;
    for (int i = 0; i < 4; i++)
      pin_detect_sel[2*i +: 2] = i[1:0];
    for (int p = 0; p < 2; p++)
    begin
      irq_pin[3:0] = {4{p[0]}};
      cyc(6);
      e = '0;
      for (int i = 0; i < 4; i++)
        e[i] = pend(i[1:0], p[0], 1'b1, p[0]);
      chk("pin_pending", e, pin_pending);
    end
    $display("pin modes done");
    pin_detect_sel[13:12] = PIRQ_DET_FALL;
    pin_filter_enable_upper[6] = 1;
    pin_filter_setting_upper[13:12] = 2'h3;
    // A short glitch must die in the filter; a long low must pass
    for (int p = 0; p < 2; p++)
    begin
      irq_pin[6] = 0;
      cyc(p ? 250 : 5);
      irq_pin[6] = 1;
      cyc(250);
      chk("pin_filter", p, pin_pending[6]);
    end
    pin_clear = '1;
    cyc(1);
    pin_clear = '0;
    cyc(1);
    chk("pin_clear", 0, pin_pending);
    $display("filter done");
    repeat (30)
    begin
      pr_req = per_req;
      pr_pend = per_pending;
      r = $random(seed);
      unit_req = r[11:0];
      unit_sel = r[17:12];
      event_link_controller_evt = r[19:18];
      r = $random(seed);
      per_req = r[15:0];
      stall = r[31:16];
      cyc(1);
      e = (((per_req & ~pr_req) | (pr_pend & stall)) & PER_EDGE) | (per_req & ~PER_EDGE);
      chk("per_pending", e, per_pending);
      for (int u = 0; u < 6; u++)
        e[u] = unit_req[2*u + unit_sel[u]];
      chk("unit_irq", e[5:0], unit_irq);
      chk("event_link", 0, event_link_pending);
    end
    $display("units done");
    {unit_req, per_req, stall, event_link_controller_evt} = '0;
    for (int g = 0; g < 7; g++)
    begin
      r = $random(seed);
      k = 32 * g + r[4:0];
      grp_edge_src[k] = 1;
      cyc(1);
      grp_edge_src = '0;
      cyc(1);
      chk("group_irq", 1, group_irq[g]);
      group_member_clears[k] = 1;
      cyc(1);
      group_member_clears = '0;
      cyc(1);
      chk("group_clear", 0, group_source_flags[k]);
    end
    repeat (8)
    begin
      r = $random(seed);
      grp_level_src = {28'h000_0000, r[3:0]};
      group_member_enables[255:224] = {28'h000_0000, r[7:4]};
      cyc(1);
      chk("level_group", |(r[3:0] & r[7:4]), group_irq[7]);
    end
    grp_level_src = '0;
    $display("groups done");
    for (int m = 1; m < 4; m++)
      for (int s = 0; s < 3; s++)
      begin
        power_mode = m[1:0];
        {clock_alarm_irq, eight_bit_timer_irq, nmi} = 3'h1 << s;
        cyc(3);
        chk("wake", m != 3 || s != 1, wake);
        {clock_alarm_irq, eight_bit_timer_irq, nmi} = 3'h0;
        cyc(3);
      end
    $display("wake done");
    print_verdict;
  end
endmodule
`default_nettype wire
